// ---- design/sct_timer.sv ----
// split capture/reload timer with its register port and second control register
module sct_timer
  import sct_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire sct_req_s bus_req,
  input wire logic [1:0] count_tick,
  input wire logic capture_pin,
  output logic [7:0] bus_rdata,
  output logic timer_irq,
  output logic [7:0] second_timer_control
);
  // ==========================================================================
  // state
  sct_ctrl_s ctrl_q, ctrl_d;
  logic [7:0] ctrl2_q, ctrl2_d;
  logic [7:0] rl_low_q, rl_low_d;
  logic [7:0] rl_high_q, rl_high_d;
  logic [7:0] cnt_low_q, cnt_low_d;
  logic [7:0] cnt_high_q, cnt_high_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic cap_s1_q, cap_s2_q, cap_s3_q;
  logic [1:0] tick_s1_q, tick_s2_q;

  logic cap_edge;
  logic run_low, run_high;
  logic cap_low, cap_high;
  logic [7:0] inc_low, inc_high;
  logic wrap_low, wrap_high;
  logic high_tick, high_carry;

  // ==========================================================================
  // pin synchronisers, the first stage is read by the second only
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cap_s1_q <= 1'b0;
      cap_s2_q <= 1'b0;
      cap_s3_q <= 1'b0;
      tick_s1_q <= 2'b00;
      tick_s2_q <= 2'b00;
    end else begin
      cap_s1_q <= capture_pin;
      cap_s2_q <= cap_s1_q;
      cap_s3_q <= cap_s2_q;
      tick_s1_q <= count_tick;
      tick_s2_q <= tick_s1_q;
    end
  end
  assign cap_edge = cap_s2_q & ~cap_s3_q;

  // ==========================================================================
  // mode decode
  always_comb begin
    // RULE2: low run gates half or whole
    run_low = ctrl_q.lower_half_run;
    // RULE1: upper run only when split
    // RULE8: wide follows the low controls
    run_high = ctrl_q.split_select ? ctrl_q.upper_half_run : ctrl_q.lower_half_run;
    // RULE11: capture enables per mode
    cap_low = ctrl_q.lower_capture_enable;
    cap_high = ctrl_q.split_select ? ctrl_q.upper_capture_enable : ctrl_q.lower_capture_enable;
    high_tick = ctrl_q.split_select ? tick_s2_q[1] : tick_s2_q[0];
    high_carry = ctrl_q.split_select ? 1'b1 : wrap_low;
  end

  sct_half #(.WIDTH(8)) u_low (
    .count(cnt_low_q),
    .tick(tick_s2_q[0] & run_low),
    .carry_in(1'b1),
    .count_inc(inc_low),
    .wrap(wrap_low)
  );

  sct_half #(.WIDTH(8)) u_high (
    .count(cnt_high_q),
    .tick(high_tick & run_high),
    .carry_in(high_carry),
    .count_inc(inc_high),
    .wrap(wrap_high)
  );

  // ==========================================================================
  // next state: counting, capture, software writes, flags
  always_comb begin
    ctrl_d = ctrl_q;
    ctrl2_d = ctrl2_q;
    rl_low_d = rl_low_q;
    rl_high_d = rl_high_q;
    cnt_low_d = inc_low;
    cnt_high_d = inc_high;
    rdata_d = rdata_q;
    // RULE12: reload on overflow in timer mode
    if (wrap_low && !cap_low && ctrl_q.split_select) begin
      cnt_low_d = rl_low_q;
    end
    if (wrap_high && !cap_high) begin
      cnt_high_d = rl_high_q;
      if (!ctrl_q.split_select) begin
        cnt_low_d = rl_low_q;
      end
    end
    // software writes first so that hardware events below win over them
    if (bus_req.wr) begin
      case (bus_req.addr)
        SCT_ADDR_FIRST_CTRL: ctrl_d = sct_ctrl_s'(bus_req.wdata);
        SCT_ADDR_SECOND_CTRL: ctrl2_d = bus_req.wdata;
        // RULE4: single buffered bytes
        SCT_ADDR_RELOAD_LOW: rl_low_d = bus_req.wdata;
        // RULE5: upper reload byte
        SCT_ADDR_RELOAD_HIGH: rl_high_d = bus_req.wdata;
        SCT_ADDR_COUNT_LOW: cnt_low_d = bus_req.wdata;
        SCT_ADDR_COUNT_HIGH: cnt_high_d = bus_req.wdata;
        default: ;
      endcase
    end
    // RULE3: capture into reload bytes
    if (cap_edge) begin
      if (cap_low) begin
        rl_low_d = cnt_low_q;
      end
      if (cap_high && (run_high || !ctrl_q.split_select)) begin
        rl_high_d = cnt_high_q;
      end
    end
    // RULE10: flags set by hardware and by control register writes
    if (wrap_low) begin
      ctrl_d.lower_event_flag = 1'b1;
    end
    if (ctrl_q.split_select) begin
      if (cap_edge && cap_low) begin
        ctrl_d.lower_event_flag = 1'b1;
      end
      if (wrap_high || (cap_edge && cap_high)) begin
        ctrl_d.upper_event_flag = 1'b1;
      end
    end else if (cap_low) begin
      // wide capture: low flag also takes the 17th bit, capture raises the upper flag
      if (wrap_high) begin
        ctrl_d.lower_event_flag = 1'b1;
      end
      if (cap_edge) begin
        ctrl_d.upper_event_flag = 1'b1;
      end
    end else if (wrap_high) begin
      ctrl_d.upper_event_flag = 1'b1;
    end
    // RULE9: interrupt request
    irq_d = ctrl_d.upper_event_flag | (ctrl_d.lower_event_flag & ctrl_d.lower_event_irq_enable);
    if (bus_req.rd) begin
      case (bus_req.addr)
        SCT_ADDR_FIRST_CTRL: rdata_d = ctrl_q;
        SCT_ADDR_SECOND_CTRL: rdata_d = ctrl2_q;
        SCT_ADDR_RELOAD_LOW: rdata_d = rl_low_q;
        SCT_ADDR_RELOAD_HIGH: rdata_d = rl_high_q;
        // RULE6: low count byte
        SCT_ADDR_COUNT_LOW: rdata_d = cnt_low_q;
        // RULE7: high count byte
        SCT_ADDR_COUNT_HIGH: rdata_d = cnt_high_q;
        default: rdata_d = SCT_RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_q <= sct_ctrl_s'(SCT_RESET_BYTE);
      ctrl2_q <= SCT_RESET_BYTE;
      rl_low_q <= SCT_RESET_BYTE;
      rl_high_q <= SCT_RESET_BYTE;
      cnt_low_q <= SCT_RESET_BYTE;
      cnt_high_q <= SCT_RESET_BYTE;
      rdata_q <= SCT_RESET_BYTE;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      ctrl2_q <= ctrl2_d;
      rl_low_q <= rl_low_d;
      rl_high_q <= rl_high_d;
      cnt_low_q <= cnt_low_d;
      cnt_high_q <= cnt_high_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign bus_rdata = rdata_q;
  assign timer_irq = irq_q;
  assign second_timer_control = ctrl2_q;
endmodule

// ---- design/sct_pkg.sv ----
// constants, field layout and carrier types of the split capture/reload timer
// What this block does
// RULE1: in split mode the upper-half run bit starts or stops only the upper half, and is ignored when wide.
// RULE2: the lower-half run bit enables the lower half when split and the whole 16-bit timer when wide.
// RULE3: the low reload/capture byte takes the captured count in capture mode and supplies the reload in timer mode.
// RULE4: both reload/capture bytes are single buffered, so a write to either byte acts at once on its own.
// RULE5: the high reload/capture byte holds the upper reload byte, is read/write and resets to zero.
// RULE6: the low count byte is the low byte of the 16-bit count when wide and the whole low-half count when split.
// RULE7: the high count byte is the high byte of the 16-bit count when wide and the whole high-half count when split.
// RULE8: with split clear the timer counts as one 16-bit timer under the lower controls, with split set the halves run apart.
// RULE9: the interrupt request is the upper flag ORed with the lower flag gated by its enable.
// RULE10: overflow and capture flags are set by hardware and cleared by software writing zero; a control write with a flag bit at one also sets it.
// RULE11: the lower capture enable selects capture for the low half or the whole timer, the upper one only when split.
// RULE12: in timer mode an overflowing counter reloads from its reload byte or bytes on the same clock.
package sct_pkg;
  // ==========================================================================
  // register addresses
  localparam logic [7:0] SCT_ADDR_FIRST_CTRL = 8'hc8;
  localparam logic [7:0] SCT_ADDR_SECOND_CTRL = 8'hb9;
  localparam logic [7:0] SCT_ADDR_RELOAD_LOW = 8'hca;
  localparam logic [7:0] SCT_ADDR_RELOAD_HIGH = 8'hcb;
  localparam logic [7:0] SCT_ADDR_COUNT_LOW = 8'hcc;
  localparam logic [7:0] SCT_ADDR_COUNT_HIGH = 8'hcd;
  localparam logic [7:0] SCT_RESET_BYTE = 8'h00;
  localparam logic [7:0] SCT_BYTE_MAX = 8'hff;

  // ==========================================================================
  // control register layout, same for both timers
  typedef struct packed {
    logic upper_event_flag;
    logic lower_event_flag;
    logic lower_event_irq_enable;
    logic split_select;
    logic upper_capture_enable;
    logic lower_capture_enable;
    logic upper_half_run;
    logic lower_half_run;
  } sct_ctrl_s;

  // register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sct_req_s;
endpackage

// ---- design/sct_half.sv ----
// one 8-bit counter half with its clock-enable and overflow detection
module sct_half
  import sct_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] count,
  input wire logic tick,
  input wire logic carry_in,
  output logic [WIDTH-1:0] count_inc,
  output logic wrap
);
  // ==========================================================================
  // increment on a tick gated by the lower carry when chained
  always_comb begin
    count_inc = count;
    wrap = 1'b0;
    if (tick && carry_in) begin
      count_inc = count + {{(WIDTH-1){1'b0}}, 1'b1};
      wrap = (count == {WIDTH{1'b1}});
    end
  end
endmodule

// ---- tb/sct_timer_checker.sv ----
// checker of the split timer register port and interrupt output
module sct_timer_checker
  import sct_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire sct_req_s bus_req,
  input wire logic [1:0] count_tick,
  input wire logic capture_pin,
  input wire logic [7:0] bus_rdata,
  input wire logic timer_irq,
  input wire logic [7:0] second_timer_control
);
  // ==========================================================================
  // port properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic w_sec;
  logic unmapped;
  assign w_sec = bus_req.wr && bus_req.addr == SCT_ADDR_SECOND_CTRL;
  assign unmapped = !(bus_req.addr inside {8'hc8, 8'hb9, 8'hca, 8'hcb, 8'hcc, 8'hcd});
  rst_clears_a: assert property ($fell(sys_rst) |-> bus_rdata == 8'h00 && !timer_irq &&
    second_timer_control == 8'h00) else $error("outputs not cleared by reset");
  ctrl_write_a: assert property (w_sec |=> second_timer_control == $past(bus_req.wdata))
    else $error("second control write lost");
  ctrl_hold_a: assert property (!w_sec |=> $stable(second_timer_control))
    else $error("second control changed without write");
  unmapped_zero_a: assert property (bus_req.rd && unmapped |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!bus_req.rd |=> $stable(bus_rdata))
    else $error("read data moved without read");
  ctrl_read_a: assert property (bus_req.rd && !bus_req.wr && bus_req.addr == 8'hb9 |=>
    bus_rdata == $past(second_timer_control)) else $error("second control read wrong");
  reload_rt_a: assert property ((bus_req.wr && !bus_req.rd && bus_req.addr == 8'hcb) ##1
    (bus_req.rd && !bus_req.wr && bus_req.addr == 8'hcb) |=> bus_rdata == $past(bus_req.wdata, 2))
    else $error("high reload byte not read back");
  irq_fall_a: assert property ($fell(timer_irq) && !$past(sys_rst) |->
    $past(bus_req.wr && bus_req.addr == 8'hc8)) else $error("irq dropped by hardware");
  irq_set_a: assert property (bus_req.wr && bus_req.addr == 8'hc8 && bus_req.wdata[7] |=>
    timer_irq) else $error("upper flag gave no irq");
endmodule
bind sct_timer sct_timer_checker chk (.core_clk, .sys_rst, .bus_req, .count_tick, .capture_pin,
  .bus_rdata, .timer_irq, .second_timer_control);

// ---- tb/test_split_capture_reload_timer.sv ----
// self-checking bench of the split capture/reload timer
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin n_mismatch++; \
  $display("mismatch %s expected %h seen %h", nm, e, s); end end
module test_split_capture_reload_timer
  import sct_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  sct_req_s bus_req = '0;
  logic [1:0] count_tick = 2'b00;
  logic capture_pin = 1'b0;
  logic [7:0] bus_rdata, second_timer_control, v;
  logic timer_irq;
  int n_mismatch = 0, tests_run = 0, cyc = 0;
  logic [7:0] tab [7] = '{8'hc8, 8'hb9, 8'hca, 8'hcb, 8'hcc, 8'hcd, 8'hce};
  always #50 core_clk = ~core_clk;
  sct_timer dut (.core_clk, .sys_rst, .bus_req, .count_tick, .capture_pin, .bus_rdata,
    .timer_irq, .second_timer_control);
  // ==========================================================================
  // bus and stimulus tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    bus_req = '{1'b1, 1'b0, a, d};
    @(negedge core_clk);
    bus_req = '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    bus_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge core_clk);
    bus_req = '0;
    v = bus_rdata;
  endtask
  // ticks reach the counter two clocks late, so allow settling afterwards
  task automatic tk(input logic [1:0] m, input int n);
    @(negedge core_clk);
    count_tick = m;
    repeat (n) @(negedge core_clk);
    count_tick = 2'b00;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic conclude();
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      conclude();
    end
  end
  // ==========================================================================
  // scenarios
  initial begin
    repeat (3) @(negedge core_clk);
    sys_rst = 1'b0;
    foreach (tab[i]) begin rd(tab[i]); `CHK("reset", 8'h00, v) end
    wr(8'hca, 8'hfe);
    wr(8'hcb, 8'h12);
    rd(8'hca); `CHK("rl_lo", 8'hfe, v)
    rd(8'hcb); `CHK("rl_hi", 8'h12, v)
    wr(8'hb9, 8'ha5); `CHK("ctrl2", 8'ha5, second_timer_control)
    wr(8'hcc, 8'hfe);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h03);
    tk(2'b10, 3); rd(8'hcc); `CHK("wide_hi_tick", 8'hfe, v)
    tk(2'b01, 3); rd(8'hcc); `CHK("cnt_lo", 8'hff, v)
    rd(8'hcd); `CHK("cnt_hi", 8'h12, v)
    rd(8'hc8); `CHK("ctrl_wide", 8'hc3, v)
    `CHK("irq_hi", 1'b1, timer_irq)
    wr(8'hc8, 8'h40); repeat (2) @(negedge core_clk); `CHK("irq_masked", 1'b0, timer_irq)
    wr(8'hc8, 8'h60); repeat (2) @(negedge core_clk); `CHK("irq_lo", 1'b1, timer_irq)
    wr(8'hc8, 8'h80); `CHK("irq_upper", 1'b1, timer_irq)
    wr(8'hc8, 8'h12);
    tk(2'b11, 2); rd(8'hcc); `CHK("split_lo", 8'hff, v)
    rd(8'hcd); `CHK("split_hi", 8'h14, v)
    wr(8'hc8, 8'h11);
    tk(2'b11, 1); rd(8'hcc); `CHK("split_reload", 8'hfe, v)
    rd(8'hcd); `CHK("hi_stopped", 8'h14, v)
    rd(8'hc8); `CHK("ctrl_split", 8'h51, v)
    wr(8'hcc, 8'h30);
    wr(8'hc8, 8'h15);
    tk(2'b01, 4);
    capture_pin = 1'b1;
    repeat (6) @(negedge core_clk);
    capture_pin = 1'b0;
    rd(8'hca); `CHK("captured", 8'h34, v)
    rd(8'hc8); `CHK("ctrl_cap", 8'h55, v)
    conclude();
  end
endmodule
